// *** hdl/lmrs_pkg.sv ***
// Package for lane mode and reset steering block.
// Assumes APB slave with 32-bit data, single clock pclk.
package lmrs_pkg;
  typedef enum logic [1:0] {
    LMRS_FULL_DUPLEX,
    LMRS_TX_ONLY,
    LMRS_RX_ONLY,
    LMRS_INDEPENDENT
  } lmrs_lane_mode_t;

  typedef enum logic [1:0] {
    LMRS_CODE_RAW,
    LMRS_CODE_8B10B,
    LMRS_CODE_64B6XB,
    LMRS_CODE_PIPE
  } lmrs_code_mode_t;

  localparam logic [11:0] LMRS_OFS_CTRL = 12'h000;
  localparam logic [11:0] LMRS_OFS_WIDTH = 12'h004;
  localparam logic [11:0] LMRS_OFS_RATE = 12'h008;
  localparam logic [11:0] LMRS_OFS_STATUS = 12'h00C;
  localparam logic [11:0] LMRS_OFS_RESET = 12'h010;

  // CTRL fields
  localparam int LMRS_CTRL_MODE_LSB = 0;
  localparam int LMRS_CTRL_CODE_LSB = 4;
  localparam int LMRS_CTRL_FRACN_BIT = 8;
  // WIDTH fields: tx width code [2:0], rx width code [6:4]
  localparam int LMRS_WID_TX_LSB = 0;
  localparam int LMRS_WID_RX_LSB = 4;
  // RATE fields: tx rate [15:0], rx rate [31:16]
  localparam int LMRS_RATE_RX_LSB = 16;
  // RESET register bits: software medium/coding reset requests
  localparam int LMRS_RST_MEDIUM_BIT = 0;
  localparam int LMRS_RST_CODING_BIT = 1;

  localparam logic [2:0] LMRS_WIDTH_DEFAULT = 3'h2;
  localparam logic [15:0] LMRS_RATE_DEFAULT = 16'h1388;
  localparam logic [1:0] LMRS_MODE_DEFAULT = 2'h0;
  localparam logic [1:0] LMRS_CODE_DEFAULT = 2'h0;
  localparam logic [4:0] LMRS_MIN_RESET_CYCLES = 5'h10;
  localparam logic [31:0] LMRS_RDATA_ZERO = 32'h0000_0000;
endpackage

// *** hdl/lmrs_top.sv ***
// Lane mode selection and reset steering for one transceiver lane.
// Assumes an APB master on pclk; lane clocks tx_clk/rx_clk from the lane.
//
// Functional notes
// - Full duplex shares clock, rate and width
// - Full duplex resets reach both halves
// - Half modes: medium both, coding used only
// - Half modes occupy the whole lane
// - Unused direction keeps valid default settings
// - Independent allows own rates, widths, refclock
// - One coding mode shared by both directions
// - Full duplex allows raw, 8b10b, 64b6xb, PIPE
// - Independent mode allows raw coding only
// - 8b10b forces equal fabric widths
// - Unused serializer or deserializer powered down
// - Transmit PLL fractional-N, receive PLL integer
`timescale 1ns/1ns
`default_nettype none

module lmrs_top
  import lmrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic medium_layer_reset_n,
  input wire logic coding_layer_reset_n,
  output logic tx_medium_rst_n,
  output logic rx_medium_rst_n,
  output logic tx_coding_rst_n,
  output logic rx_coding_rst_n,
  output logic ser_power_down,
  output logic deser_power_down,
  output logic lane_occupied,
  output logic aux_refclk_en,
  output logic [1:0] code_mode,
  output logic [2:0] tx_width,
  output logic [2:0] rx_width,
  output logic [15:0] tx_rate,
  output logic [15:0] rx_rate,
  output logic tx_pll_fracn,
  output logic rx_pll_fracn
);
  import lmrs_pkg::*;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [1:0] mode_q;
  logic [1:0] code_q;
  logic fracn_q;
  logic [2:0] txw_q;
  logic [2:0] rxw_q;
  logic [15:0] txr_q;
  logic [15:0] rxr_q;
  logic cfg_err_q;
  logic sw_med_q;
  logic sw_cod_q;
  logic [4:0] med_low_cnt_q;
  logic med_short_q;
  logic [3:0] lane_rst_seen;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire sel_ctrl = paddr == LMRS_OFS_CTRL;
  wire sel_width = paddr == LMRS_OFS_WIDTH;
  wire sel_rate = paddr == LMRS_OFS_RATE;
  wire sel_status = paddr == LMRS_OFS_STATUS;
  wire sel_reset = paddr == LMRS_OFS_RESET;
  wire mapped = sel_ctrl || sel_width || sel_rate || sel_status || sel_reset;

  // ----------------------------------------------------------------
  // Configuration check on write
  // ----------------------------------------------------------------
  wire [1:0] new_mode = pwdata[LMRS_CTRL_MODE_LSB +: 2];
  wire [1:0] new_code = pwdata[LMRS_CTRL_CODE_LSB +: 2];
  wire new_half = (new_mode == LMRS_TX_ONLY) || (new_mode == LMRS_RX_ONLY);
  wire new_indep = new_mode == LMRS_INDEPENDENT;
  wire code_ok_ctrl = new_indep ? (new_code == LMRS_CODE_RAW) :
                      new_half ? (new_code == LMRS_CODE_RAW ||
                                  new_code == LMRS_CODE_8B10B) : 1'b1;
  wire [2:0] new_txw = pwdata[LMRS_WID_TX_LSB +: 3];
  wire [2:0] new_rxw = pwdata[LMRS_WID_RX_LSB +: 3];
  wire split_ok = (mode_q == LMRS_INDEPENDENT);
  wire width_ok = (new_txw == new_rxw) || (split_ok && code_q != LMRS_CODE_8B10B);
  wire rate_ok = (pwdata[15:0] == pwdata[LMRS_RATE_RX_LSB +: 16]) || split_ok;
  wire bad_wr = wr && ((sel_ctrl && !code_ok_ctrl) || (sel_width && !width_ok) ||
                       (sel_rate && !rate_ok));
  wire [31:0] rd_mux =
    sel_ctrl ? {23'h0, fracn_q, 2'h0, code_q, 2'h0, mode_q} :
    sel_width ? {25'h0, rxw_q, 1'b0, txw_q} :
    sel_rate ? {rxr_q, txr_q} :
    sel_status ? {26'h0, med_short_q, cfg_err_q, lane_rst_seen} :
    sel_reset ? {30'h0, sw_cod_q, sw_med_q} : LMRS_RDATA_ZERO;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire wr_take = wr && pready;
  wire wr_ctrl = wr_take && !bad_wr && sel_ctrl;
  wire wr_width = wr_take && !bad_wr && sel_width;
  wire wr_rate = wr_take && !bad_wr && sel_rate;
  wire wr_reset = wr_take && sel_reset;
  wire cfg_clear = wr_ctrl || wr_width || wr_rate;
  wire cfg_set = wr_take && bad_wr;

  // Bus answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= LMRS_RDATA_ZERO;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || (pwrite && sel_status));
      prdata <= (psel && !penable && !pwrite) ? rd_mux : LMRS_RDATA_ZERO;
    end
  end

  // Lane configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= LMRS_MODE_DEFAULT;
      code_q <= LMRS_CODE_DEFAULT;
      fracn_q <= 1'b0;
      txw_q <= LMRS_WIDTH_DEFAULT;
      rxw_q <= LMRS_WIDTH_DEFAULT;
      txr_q <= LMRS_RATE_DEFAULT;
      rxr_q <= LMRS_RATE_DEFAULT;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_q <= new_mode;
        code_q <= new_code;
        fracn_q <= pwdata[LMRS_CTRL_FRACN_BIT];
        if (new_mode != LMRS_INDEPENDENT)
        begin
          rxw_q <= txw_q;
          rxr_q <= txr_q;
        end
      end
      if (wr_width)
      begin
        txw_q <= new_txw;
        rxw_q <= new_rxw;
      end
      if (wr_rate)
      begin
        txr_q <= pwdata[15:0];
        rxr_q <= pwdata[LMRS_RATE_RX_LSB +: 16];
      end
    end
  end

  // Software reset requests and config error flag, cleared by an accepted config write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_med_q <= 1'b0;
      sw_cod_q <= 1'b0;
      cfg_err_q <= 1'b0;
    end
    else
    begin
      if (wr_reset)
      begin
        sw_med_q <= pwdata[LMRS_RST_MEDIUM_BIT];
        sw_cod_q <= pwdata[LMRS_RST_CODING_BIT];
      end
      if (cfg_set)
        cfg_err_q <= 1'b1;
      else if (cfg_clear)
        cfg_err_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Medium reset pulse width watch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      med_low_cnt_q <= 5'h00;
      med_short_q <= 1'b0;
    end
    else if (!medium_layer_reset_n)
    begin
      if (med_low_cnt_q != LMRS_MIN_RESET_CYCLES)
        med_low_cnt_q <= med_low_cnt_q + 5'h01;
    end
    else
    begin
      med_low_cnt_q <= 5'h00;
      if (med_low_cnt_q != 5'h00 && med_low_cnt_q < LMRS_MIN_RESET_CYCLES)
        med_short_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Reset steering
  // ----------------------------------------------------------------
  wire is_tx_only = mode_q == LMRS_TX_ONLY;
  wire is_rx_only = mode_q == LMRS_RX_ONLY;
  wire med_n = medium_layer_reset_n && !sw_med_q && presetn;
  wire cod_n = coding_layer_reset_n && !sw_cod_q && presetn;
  wire tx_med_src = med_n;
  wire rx_med_src = med_n;
  wire tx_cod_src = med_n && (cod_n || is_rx_only);
  wire rx_cod_src = med_n && (cod_n || is_tx_only);

  lmrs_rst_sync u_tx_med (.clk(tx_clk), .arst_n(tx_med_src), .rst_n(tx_medium_rst_n));
  lmrs_rst_sync u_rx_med (.clk(rx_clk), .arst_n(rx_med_src), .rst_n(rx_medium_rst_n));
  lmrs_rst_sync u_tx_cod (.clk(tx_clk), .arst_n(tx_cod_src), .rst_n(tx_coding_rst_n));
  lmrs_rst_sync u_rx_cod (.clk(rx_clk), .arst_n(rx_cod_src), .rst_n(rx_coding_rst_n));

  // Lane reset levels brought into pclk for status
  lmrs_stat_sync u_status_sync (.clk(pclk), .arst_n(presetn),
    .d({rx_coding_rst_n, tx_coding_rst_n, rx_medium_rst_n, tx_medium_rst_n}),
    .q(lane_rst_seen));

  // ----------------------------------------------------------------
  // Lane configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ser_power_down <= 1'b0;
      deser_power_down <= 1'b0;
      lane_occupied <= 1'b0;
      aux_refclk_en <= 1'b0;
      code_mode <= LMRS_CODE_DEFAULT;
      tx_width <= LMRS_WIDTH_DEFAULT;
      rx_width <= LMRS_WIDTH_DEFAULT;
      tx_rate <= LMRS_RATE_DEFAULT;
      rx_rate <= LMRS_RATE_DEFAULT;
      tx_pll_fracn <= 1'b0;
      rx_pll_fracn <= 1'b0;
    end
    else
    begin
      deser_power_down <= is_tx_only;
      ser_power_down <= is_rx_only;
      lane_occupied <= is_tx_only || is_rx_only;
      aux_refclk_en <= mode_q == LMRS_INDEPENDENT;
      code_mode <= code_q;
      tx_width <= is_rx_only ? LMRS_WIDTH_DEFAULT : txw_q;
      rx_width <= is_tx_only ? LMRS_WIDTH_DEFAULT : rxw_q;
      tx_rate <= is_rx_only ? LMRS_RATE_DEFAULT : txr_q;
      rx_rate <= is_tx_only ? LMRS_RATE_DEFAULT : rxr_q;
      tx_pll_fracn <= fracn_q;
      rx_pll_fracn <= 1'b0;
    end
  end
endmodule // lmrs_top

// Async-assert, synchronous-release reset for one lane half
module lmrs_rst_sync
(
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n
);
  logic meta_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      meta_q <= 1'b1;
      rst_n <= meta_q;
    end
  end
endmodule // lmrs_rst_sync

// Two-flop capture of lane reset levels into the bus clock
module lmrs_stat_sync
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] d,
  output logic [3:0] q
);
  logic [3:0] meta_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 4'h0;
      q <= 4'h0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // lmrs_stat_sync

`default_nettype wire

// *** sim/lmrs_fabric.sv ***
// Fabric-side model driving the two lane reset inputs.
// Assumes one-cycle go strobes and a hold count from the bench.
`timescale 1ns/1ns
`default_nettype none
module lmrs_fabric (
  input wire logic clk,
  input wire logic med_go,
  input wire logic cod_go,
  input wire logic [7:0] hold,
  output logic medium_layer_reset_n,
  output logic coding_layer_reset_n
);
  logic [7:0] med_q = 8'h00;
  logic [7:0] cod_q = 8'h00;
  always @(posedge clk)
  begin
    med_q <= med_go ? hold : med_q - {7'h00, med_q != 8'h00};
    cod_q <= cod_go ? hold : cod_q - {7'h00, cod_q != 8'h00};
  end
  assign medium_layer_reset_n = (med_q == 8'h00);
  assign coding_layer_reset_n = (cod_q == 8'h00);
endmodule // lmrs_fabric
`default_nettype wire

// *** sim/lmrs_top_props.sv ***
// Port checker for lmrs_top.
// Assumes binding into lmrs_top, all checks on pclk.
`timescale 1ns/1ns
`default_nettype none
module lmrs_top_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic medium_layer_reset_n,
  input wire logic coding_layer_reset_n,
  input wire logic tx_medium_rst_n,
  input wire logic rx_medium_rst_n,
  input wire logic tx_coding_rst_n,
  input wire logic rx_coding_rst_n,
  input wire logic ser_power_down,
  input wire logic deser_power_down,
  input wire logic lane_occupied,
  input wire logic aux_refclk_en,
  input wire logic [1:0] code_mode,
  input wire logic [2:0] tx_width,
  input wire logic [2:0] rx_width,
  input wire logic rx_pll_fracn
);
  import lmrs_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready is not a one cycle answer");
  half_lane_a: assert property (lane_occupied == (ser_power_down ^ deser_power_down))
    else $error("lane use and power down disagree");
  indep_raw_a: assert property (aux_refclk_en |-> !lane_occupied && code_mode == 2'h0)
    else $error("independent mode with coding");
  half_code_a: assert property (lane_occupied |-> !code_mode[1])
    else $error("half mode with wide coding");
  code_width_a: assert property (code_mode == 2'h1 && !lane_occupied |->
    tx_width == rx_width)
    else $error("8b10b with unequal widths");
  rx_default_a: assert property (deser_power_down |-> rx_width == LMRS_WIDTH_DEFAULT)
    else $error("unused receive width not default");
  tx_default_a: assert property (ser_power_down |-> tx_width == LMRS_WIDTH_DEFAULT)
    else $error("unused transmit width not default");
  duplex_width_a: assert property (!lane_occupied && !aux_refclk_en |-> tx_width == rx_width)
    else $error("duplex widths differ");
  rx_integer_a: assert property (!rx_pll_fracn)
    else $error("receive pll fractional");
  medium_both_a: assert property (!medium_layer_reset_n |-> !tx_medium_rst_n && !rx_medium_rst_n)
    else $error("medium reset missed a half");
  coding_both_a: assert property (!coding_layer_reset_n && !lane_occupied |->
    !tx_coding_rst_n && !rx_coding_rst_n)
    else $error("duplex coding reset missed a half");
  coding_half_a: assert property (deser_power_down && $fell(coding_layer_reset_n) &&
    rx_coding_rst_n |=> rx_coding_rst_n && !tx_coding_rst_n)
    else $error("transmit only coding reset wrong");
endmodule // lmrs_top_props
bind lmrs_top lmrs_top_props u_props (.pclk, .presetn, .psel, .penable, .pready,
  .medium_layer_reset_n, .coding_layer_reset_n, .tx_medium_rst_n, .rx_medium_rst_n,
  .tx_coding_rst_n, .rx_coding_rst_n, .ser_power_down, .deser_power_down, .lane_occupied,
  .aux_refclk_en, .code_mode, .tx_width, .rx_width, .rx_pll_fracn);
`default_nettype wire

// *** sim/lmrs_top_tb.sv ***
// Testbench for lmrs_top: lane modes, registers and reset steering.
// Assumes lmrs_fabric drives the fabric resets, checker bound.
`timescale 1ns/1ns
`default_nettype none
module lmrs_top_tb;
  import lmrs_pkg::*;
  typedef struct packed {logic [11:0] ctrl; logic [7:0] exp; logic err;} lmrs_row_t;
  logic pclk, presetn, psel, penable, pwrite, tx_clk, rx_clk, med_go, cod_go, er;
  logic pready, pslverr, tx_medium_rst_n, rx_medium_rst_n, tx_coding_rst_n, rx_coding_rst_n;
  logic ser_power_down, deser_power_down, lane_occupied, aux_refclk_en, tx_pll_fracn;
  logic rx_pll_fracn, medium_layer_reset_n, coding_layer_reset_n;
  logic [1:0] code_mode;
  logic [2:0] tx_width, rx_width;
  logic [7:0] hold;
  logic [11:0] paddr;
  logic [15:0] tx_rate, rx_rate;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch = 0;
  int checks = 0;
  lmrs_row_t rows [12] = '{'{12'h000, 8'h00, 1'b0}, '{12'h010, 8'h01, 1'b0},
    '{12'h020, 8'h02, 1'b0}, '{12'h030, 8'h03, 1'b0}, '{12'h100, 8'h80, 1'b0},
    '{12'h011, 8'h19, 1'b0}, '{12'h002, 8'h28, 1'b0}, '{12'h003, 8'h04, 1'b0},
    '{12'h013, 8'h04, 1'b1}, '{12'h021, 8'h04, 1'b1}, '{12'h032, 8'h04, 1'b1},
    '{12'h001, 8'h18, 1'b0}};
  lmrs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_clk, .rx_clk, .medium_layer_reset_n, .coding_layer_reset_n, .tx_medium_rst_n,
    .rx_medium_rst_n, .tx_coding_rst_n, .rx_coding_rst_n, .ser_power_down, .deser_power_down,
    .lane_occupied, .aux_refclk_en, .code_mode, .tx_width, .rx_width, .tx_rate, .rx_rate,
    .tx_pll_fracn, .rx_pll_fracn);
  lmrs_fabric fab (.clk(pclk), .med_go, .cod_go, .hold, .medium_layer_reset_n,
    .coding_layer_reset_n);
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always #8 tx_clk = ~tx_clk;
  always #9 rx_clk = ~rx_clk;
  // ---
  // Helpers
  // ---
  function automatic logic [7:0] obs();
    return {tx_pll_fracn, rx_pll_fracn, ser_power_down, deser_power_down, lane_occupied,
      aux_refclk_en, code_mode};
  endfunction
  function automatic logic [3:0] lanes();
    return {tx_coding_rst_n, rx_coding_rst_n, tx_medium_rst_n, rx_medium_rst_n};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge pclk);
      k++;
    end
    if (k == 20)
    begin
      n_mismatch++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic pulse(input logic m, input logic [3:0] e);
    med_go <= m;
    cod_go <= !m;
    @(posedge pclk);
    med_go <= 1'b0;
    cod_go <= 1'b0;
    repeat (3) @(posedge pclk);
    cmp(lanes(), e);
    repeat (40) @(posedge pclk);
    cmp(lanes(), 4'hF);
  endtask
  // ---
  // Main sequence
  // ---
  initial
  begin
    {presetn, psel, penable, pwrite, med_go, cod_go, tx_clk, rx_clk} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    hold = 8'h10;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    cmp(lanes(), 4'hF);
    foreach (rows[i])
    begin
      apb(1'b1, LMRS_OFS_CTRL, {20'h0, rows[i].ctrl});
      @(posedge pclk);
      cmp(obs(), rows[i].exp);
      apb(1'b0, LMRS_OFS_STATUS, 32'h0);
      cmp(rd[4], rows[i].err);
    end
    $display("test mode table done");
    apb(1'b1, LMRS_OFS_WIDTH, 32'h33);
    @(posedge pclk);
    cmp({tx_width, rx_width, rx_rate}, {3'h3, 3'h2, 16'h1388});
    apb(1'b1, LMRS_OFS_CTRL, 32'h3);
    apb(1'b1, LMRS_OFS_WIDTH, 32'h53);
    apb(1'b1, LMRS_OFS_RATE, 32'h0BB8_1388);
    @(posedge pclk);
    cmp({tx_width, rx_width, tx_rate, rx_rate}, {3'h3, 3'h5, 16'h1388, 16'h0BB8});
    apb(1'b1, LMRS_OFS_CTRL, 32'h10);
    apb(1'b1, LMRS_OFS_WIDTH, 32'h53);
    @(posedge pclk);
    cmp({tx_width, rx_width}, 6'h1B);
    apb(1'b0, LMRS_OFS_STATUS, 32'h0);
    cmp(rd[4], 1'b1);
    apb(1'b0, 12'h014, 32'h0);
    cmp(er, 1'b1);
    apb(1'b1, LMRS_OFS_STATUS, 32'h0);
    cmp(er, 1'b1);
    $display("test widths and refusals done");
    pulse(1'b0, 4'h3);
    pulse(1'b1, 4'h0);
    apb(1'b0, LMRS_OFS_STATUS, 32'h0);
    cmp(rd[5], 1'b0);
    apb(1'b1, LMRS_OFS_CTRL, 32'h1);
    pulse(1'b0, 4'h7);
    pulse(1'b1, 4'h0);
    hold <= 8'h04;
    pulse(1'b1, 4'h0);
    apb(1'b0, LMRS_OFS_STATUS, 32'h0);
    cmp(rd[5], 1'b1);
    $display("test steering done");
    apb(1'b1, LMRS_OFS_RESET, 32'h1);
    repeat (2) @(posedge pclk);
    cmp(lanes(), 4'h0);
    apb(1'b0, LMRS_OFS_RESET, 32'h0);
    cmp(rd[1:0], 2'h1);
    apb(1'b0, LMRS_OFS_STATUS, 32'h0);
    cmp(rd[3:0], 4'h0);
    apb(1'b1, LMRS_OFS_RESET, 32'h2);
    repeat (5) @(posedge pclk);
    cmp(lanes(), 4'h7);
    apb(1'b1, LMRS_OFS_RESET, 32'h0);
    repeat (5) @(posedge pclk);
    apb(1'b0, LMRS_OFS_STATUS, 32'h0);
    cmp(rd[3:0], 4'hF);
    $display("test software reset done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp({tx_width, rx_width, code_mode, lanes()}, 12'h480);
    cmp({tx_rate, rx_rate}, 32'h1388_1388);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, LMRS_OFS_STATUS, 32'h0);
    cmp(rd[5:4], 2'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule // lmrs_top_tb
`default_nettype wire
